// *** rtl/fpw_decoder.sv ***
// fpw_decoder.sv: maps 16-bit cpu addresses onto on-chip flash pages
// assumes: cpu bus and page-select value on mclk; flash array samples
// the registered request one cycle after the address
`timescale 1ns/1ps
`include "fpw_map.svh"
module fpw_decoder #(
  parameter fpw_pkg::fpw_variant_e VARIANT = fpw_pkg::FPW_V128
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [15:0] cpuAddr,
  input wire logic cpuValid,
  input wire logic pageSelWr,
  input wire logic [5:0] pageSelData,
  input wire logic flashMapEnable,
  input wire logic flashHalfMap,
  output fpw_pkg::fpw_flash_req_s flashReq,
  output logic [5:0] pageSelRegOut
);
  logic [5:0] page_select_reg_r;
  fpw_pkg::fpw_flash_req_s flashReq_r, flashReq_nxt;
  logic [1:0] cpuWin;

  // top two address bits pick one of the four 16K windows
  function automatic logic [1:0] winOf(input logic [15:0] a);
    return a[`FPW_WIN_HI:`FPW_WIN_LO];
  endfunction

  assign cpuWin = winOf(cpuAddr);

  // pages selectable through the paged window, per variant
  function automatic logic [5:0] pagedPage(input logic [5:0] sel);
    logic [5:0] pg;
    pg = `FPW_PAGE_TOP;
    unique case (VARIANT)
      fpw_pkg::FPW_V128: pg = `FPW_PAGE_BASE128 | {3'h0, sel[2:0]};
      fpw_pkg::FPW_V96: pg = `FPW_PAGE_BASE128 | {3'h0, sel[2:0]};
      fpw_pkg::FPW_V64: pg = `FPW_PAGE_BASE64 | {4'h0, sel[1:0]};
      fpw_pkg::FPW_V32: pg = `FPW_PAGE_BASE32 | {5'h00, sel[0]};
      fpw_pkg::FPW_V16: pg = `FPW_PAGE_TOP;
    endcase
    return pg;
  endfunction

  // software loads the page before touching the window
  always_ff @(posedge mclk) begin
    if (srst) begin
      page_select_reg_r <= `FPW_PAGE_RST;
    end else if (pageSelWr) begin
      page_select_reg_r <= pageSelData;
    end
  end

  // only internal flash is addressed; no extended address lines exist
  always_comb begin
    logic [5:0] pp;
    pp = pagedPage(page_select_reg_r);
    flashReq_nxt = '0;
    flashReq_nxt.offset = cpuAddr[`FPW_OFS_W-1:0];
    unique case (winOf(cpuAddr))
      `FPW_WIN_TOP: begin
        flashReq_nxt.hit = cpuValid && flashMapEnable;
        flashReq_nxt.page = `FPW_PAGE_TOP;
      end
      `FPW_WIN_PAGED: begin
        // 96K part has no 38/39: those selections see nothing
        flashReq_nxt.hit = cpuValid && !(VARIANT == fpw_pkg::FPW_V96 &&
          pp < `FPW_PAGE_MIN96);
        flashReq_nxt.page = pp;
      end
      `FPW_WIN_MID: begin
        flashReq_nxt.hit = cpuValid && flashMapEnable && !flashHalfMap &&
          VARIANT != fpw_pkg::FPW_V16;
        flashReq_nxt.page = `FPW_PAGE_MID;
      end
      `FPW_WIN_LOW: begin
        flashReq_nxt.hit = cpuValid && flashMapEnable &&
          VARIANT != fpw_pkg::FPW_V32;
        flashReq_nxt.page = `FPW_PAGE_LOW;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      flashReq_r <= '0;
    end else begin
      flashReq_r <= flashReq_nxt;
    end
  end

  assign flashReq = flashReq_r;
  assign pageSelRegOut = page_select_reg_r;

  // checks
  top_window_a: assert property (@(posedge mclk) disable iff (srst)
    cpuValid && flashMapEnable && cpuAddr[15:14] == `FPW_WIN_TOP
    |=> flashReq.hit && flashReq.page == `FPW_PAGE_TOP)
    else $error("top window not page 3F");
  top_off_a: assert property (@(posedge mclk) disable iff (srst)
    !flashMapEnable && cpuAddr[15:14] != `FPW_WIN_PAGED |=> !flashReq.hit)
    else $error("fixed window hit with flash disabled");
  mid_window_a: assert property (@(posedge mclk) disable iff (srst)
    cpuValid && cpuAddr[15:14] == `FPW_WIN_MID
    |=> flashReq.hit == $past(flashMapEnable && !flashHalfMap &&
      VARIANT != fpw_pkg::FPW_V16))
    else $error("mid window hit wrong");
  low_window_a: assert property (@(posedge mclk) disable iff (srst)
    cpuValid && cpuAddr[15:14] == `FPW_WIN_LOW
    |=> flashReq.hit == $past(flashMapEnable && VARIANT != fpw_pkg::FPW_V32)
      && (!flashReq.hit || flashReq.page == `FPW_PAGE_LOW))
    else $error("low window hit wrong");
  paged_load_a: assert property (@(posedge mclk) disable iff (srst)
    VARIANT == fpw_pkg::FPW_V128 && pageSelWr ##1
    (cpuValid && cpuWin == `FPW_WIN_PAGED)
    |=> flashReq.page[2:0] == $past(pageSelData[2:0], 2))
    else $error("paged window ignores page select");
  paged_128_a: assert property (@(posedge mclk) disable iff (srst)
    VARIANT == fpw_pkg::FPW_V128 && cpuValid &&
    cpuAddr[15:14] == `FPW_WIN_PAGED
    |=> flashReq.hit && flashReq.page ==
      (`FPW_PAGE_BASE128 | {3'h0, $past(page_select_reg_r[2:0])}))
    else $error("128K page decode wrong");
  paged_small_a: assert property (@(posedge mclk) disable iff (srst)
    cpuValid && cpuAddr[15:14] == `FPW_WIN_PAGED &&
    VARIANT == fpw_pkg::FPW_V32
    |=> flashReq.page ==
      (`FPW_PAGE_BASE32 | {5'h00, $past(page_select_reg_r[0])}))
    else $error("32K page decode wrong");
  paged_64_a: assert property (@(posedge mclk) disable iff (srst)
    VARIANT == fpw_pkg::FPW_V64 && cpuValid &&
    cpuWin == `FPW_WIN_PAGED
    |=> flashReq.hit && flashReq.page ==
      (`FPW_PAGE_BASE64 | {4'h0, $past(page_select_reg_r[1:0])}))
    else $error("64K page decode wrong");
  // 96K: selections of 38/39 must not reach the array
  paged_96_a: assert property (@(posedge mclk) disable iff (srst)
    VARIANT == fpw_pkg::FPW_V96 && cpuValid &&
    cpuWin == `FPW_WIN_PAGED
    |=> flashReq.hit == ($past(page_select_reg_r[2:1]) != 2'h0) &&
      (!flashReq.hit || flashReq.page ==
      (`FPW_PAGE_BASE128 | {3'h0, $past(page_select_reg_r[2:0])})))
    else $error("96K page decode wrong");
  paged_16_a: assert property (@(posedge mclk) disable iff (srst)
    VARIANT == fpw_pkg::FPW_V16 && cpuValid &&
    cpuWin == `FPW_WIN_PAGED
    |=> flashReq.hit && flashReq.page == `FPW_PAGE_TOP)
    else $error("16K paged window not top page");
  mid_page_a: assert property (@(posedge mclk) disable iff (srst)
    cpuValid && cpuWin == `FPW_WIN_MID
    |=> flashReq.page == `FPW_PAGE_MID)
    else $error("mid window page wrong");
  // every hit lands in the on-chip page range, never beyond it
  on_chip_a: assert property (@(posedge mclk) disable iff (srst)
    flashReq.hit |-> flashReq.page >= `FPW_PAGE_BASE128)
    else $error("hit outside on-chip pages");
  sel_load_a: assert property (@(posedge mclk) disable iff (srst)
    pageSelWr |=> pageSelRegOut == $past(pageSelData))
    else $error("page select not loaded");
  sel_hold_a: assert property (@(posedge mclk) disable iff (srst)
    !pageSelWr |=> $stable(pageSelRegOut))
    else $error("page select changed without write");
  reset_clear_a: assert property (@(posedge mclk)
    srst |=> flashReq == '0 && pageSelRegOut == `FPW_PAGE_RST)
    else $error("reset did not clear outputs");
  offset_pass_a: assert property (@(posedge mclk) disable iff (srst)
    flashReq.hit |-> flashReq.offset == $past(cpuAddr[`FPW_OFS_W-1:0]))
    else $error("offset corrupted");
  idle_a: assert property (@(posedge mclk) disable iff (srst)
    !cpuValid |=> !flashReq.hit)
    else $error("hit without access");

  top_cov: cover property (@(posedge mclk) disable iff (srst)
    flashReq.hit && flashReq.page == `FPW_PAGE_TOP);
  paged_cov: cover property (@(posedge mclk) disable iff (srst)
    pageSelWr ##1 cpuValid && cpuAddr[15:14] == `FPW_WIN_PAGED);
  halfmap_cov: cover property (@(posedge mclk) disable iff (srst)
    cpuValid && flashHalfMap && cpuAddr[15:14] == `FPW_WIN_MID);
  low_cov: cover property (@(posedge mclk) disable iff (srst)
    flashReq.hit && flashReq.page == `FPW_PAGE_LOW);
  refuse_cov: cover property (@(posedge mclk) disable iff (srst)
    cpuValid && cpuWin == `FPW_WIN_PAGED ##1 !flashReq.hit);
endmodule // fpw_decoder

// *** rtl/fpw_map.svh ***
// fpw_map.svh: constants for the flash page window decoder
// assumes: included by the package and the decoder module
// Operation
// - no external paging, on-chip flash only
// - paged window uses page-select register value, except 16K (always 3F)
// - page 3F at top window when enabled
// - page 3E mid window when enabled, unless half-map, not 16K
// - page 3D low window when enabled, not 32K
// - 128K part: low three bits pick 38..3F
`ifndef FPW_MAP_SVH
`define FPW_MAP_SVH
`define FPW_WIN_HI 15
`define FPW_WIN_LO 14
`define FPW_WIN_LOW 2'h0
`define FPW_WIN_MID 2'h1
`define FPW_WIN_PAGED 2'h2
`define FPW_WIN_TOP 2'h3
`define FPW_PAGE_TOP 6'h3F
`define FPW_PAGE_MID 6'h3E
`define FPW_PAGE_LOW 6'h3D
`define FPW_PAGE_BASE128 6'h38
`define FPW_PAGE_BASE64 6'h3C
`define FPW_PAGE_BASE32 6'h3E
`define FPW_PAGE_MIN96 6'h3A
`define FPW_PAGE_RST 6'h00
`define FPW_OFS_W 14
`endif

// *** rtl/fpw_pkg.sv ***
// fpw_pkg.sv: types for the flash page window decoder
// assumes: fpw_map.svh alongside
`include "fpw_map.svh"
package fpw_pkg;
  typedef enum logic [4:0] {
    FPW_V16 = 5'h01,
    FPW_V32 = 5'h02,
    FPW_V64 = 5'h04,
    FPW_V96 = 5'h08,
    FPW_V128 = 5'h10
  } fpw_variant_e;
  typedef struct packed {
    logic hit;
    logic [5:0] page;
    logic [`FPW_OFS_W-1:0] offset;
  } fpw_flash_req_s;
endpackage

// *** dv/fpw_cpu_model.sv ***
// fpw_cpu_model.sv: cpu side issuing bus addresses
// assumes: called by the bench just after a rising mclk edge
`timescale 1ns/1ps
module fpw_cpu_model (
  output logic [15:0] cpuAddr,
  output logic cpuValid
);
  initial begin
    cpuAddr = 16'h0000;
    cpuValid = 1'b0;
  end
  task automatic issue(input logic [15:0] a, input logic v);
    cpuAddr = a;
    cpuValid = v;
  endtask
endmodule // fpw_cpu_model

// *** dv/flash_page_window_decoder_tb.sv ***
// flash_page_window_decoder_tb.sv: bench for all five decoder variants
// assumes: fpw_pkg and fpw_decoder compiled first
`timescale 1ns/1ps
module flash_page_window_decoder_tb;
  logic mclk, srst, pageSelWr, flashMapEnable, flashHalfMap;
  logic [5:0] pageSelData, selNow, s2;
  logic [15:0] cpuAddr;
  logic cpuValid;
  fpw_pkg::fpw_flash_req_s flashReq[5];
  logic [5:0] pageSelRegOut[5];
  logic [4:0][20:0] expQ[$];
  logic [4:0][20:0] e2;
  logic [5:0] selQ[$];
  int n_mismatch = 0, check_count = 0, cyc = 0;
  fpw_cpu_model cpu (.cpuAddr(cpuAddr), .cpuValid(cpuValid));
  // one decoder per variant; index k is bit k of the variant code
  for (genvar k = 0; k < 5; k++) begin : gv
    fpw_decoder #(
      .VARIANT(fpw_pkg::fpw_variant_e'(5'h01 << k))
    ) DUT (.mclk(mclk), .srst(srst), .cpuAddr(cpuAddr),
      .cpuValid(cpuValid), .pageSelWr(pageSelWr),
      .pageSelData(pageSelData), .flashMapEnable(flashMapEnable),
      .flashHalfMap(flashHalfMap), .flashReq(flashReq[k]),
      .pageSelRegOut(pageSelRegOut[k]));
  end
  // k: 0 16K, 1 32K, 2 64K, 3 96K, 4 128K
  function automatic logic [20:0] expOf(input int k, input logic [15:0] a,
      input logic v, input logic [5:0] s, input logic en, input logic hm);
    logic h;
    logic [5:0] p;
    case (a[15:14])
      2'h0: h = v & en & (k != 1);
      2'h1: h = v & en & ~hm & (k != 0);
      2'h2: h = v & ~(k == 3 && s[2:1] == 2'h0);
      default: h = v & en;
    endcase
    case (a[15:14])
      2'h0: p = 6'h3D;
      2'h1: p = 6'h3E;
      2'h3: p = 6'h3F;
      default: p = (k == 0) ? 6'h3F : (k == 1) ? {5'h1F, s[0]} :
        (k == 2) ? {4'hF, s[1:0]} : {3'h7, s[2:0]};
    endcase
    return {h, p, a[13:0]};
  endfunction
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input string nm, input logic [20:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // note queued at the sampling edge, so a write there is not yet seen
  task automatic op(input logic [15:0] a, input logic v, input logic wr,
                    input logic [5:0] d, input logic en, input logic hm);
    logic [4:0][20:0] e;
    #1 cpu.issue(a, v);
    pageSelWr = wr;
    pageSelData = d;
    flashMapEnable = en;
    flashHalfMap = hm;
    for (int k = 0; k < 5; k++) e[k] = expOf(k, a, v, selNow, en, hm);
    @(posedge mclk);
    expQ.push_back(e);
    if (wr) selNow = d;
    selQ.push_back(selNow);
  endtask
  always @(negedge mclk) begin
    if (expQ.size() > 0) begin
      e2 = expQ.pop_front();
      s2 = selQ.pop_front();
      for (int k = 0; k < 5; k++) begin
        if (e2[k][20]) check("flashReq", flashReq[k], e2[k]);
        else check("hit", {20'h0, flashReq[k].hit}, 21'h0);
        check("pageSel", {15'h0, pageSelRegOut[k]}, {15'h0, s2});
      end
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    srst = 1'b1;
    pageSelWr = 1'b0;
    pageSelData = 6'h00;
    flashMapEnable = 1'b0;
    flashHalfMap = 1'b0;
    selNow = 6'h00;
    void'($urandom(75));
    repeat (10) @(posedge mclk);
    #1 srst = 1'b0;
    for (int k = 0; k < 5; k++) check("rstReq", flashReq[k], 21'h0);
    @(posedge mclk);
    op(16'h0000, 1'b1, 1'b1, 6'h05, 1'b1, 1'b0);
    op(16'h8123, 1'b1, 1'b0, 6'h00, 1'b1, 1'b0);
    op(16'hBFFF, 1'b1, 1'b1, 6'h3F, 1'b0, 1'b1);
    op(16'hBFFF, 1'b1, 1'b1, 6'h08, 1'b0, 1'b1);
    op(16'h8001, 1'b1, 1'b0, 6'h00, 1'b1, 1'b0);
    op(16'h4000, 1'b1, 1'b0, 6'h00, 1'b1, 1'b1);
    op(16'hC000, 1'b0, 1'b0, 6'h00, 1'b1, 1'b0);
    for (int i = 0; i < 400; i++)
      op(16'($urandom), 1'($urandom), 1'($urandom), 6'($urandom),
         1'($urandom), 1'($urandom));
    repeat (2) @(posedge mclk);
    conclude();
  end
endmodule // flash_page_window_decoder_tb
